// ---- shared/prc_defs.svh ----
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH

// Boot memory geometry
`define PRC_OTP_BYTES 128
`define PRC_OTP_AW 7

// Hidden correction area starts here (repair table and ECC bytes)
`define PRC_OTP_USER_LIMIT 7'h70

// Power-up settle time in ns and derived cycles at 40 MHz
`define PRC_CLK_NS 25
`define PRC_SETTLE_NS 1000
`define PRC_SETTLE_CYC ((`PRC_SETTLE_NS + `PRC_CLK_NS - 1) / `PRC_CLK_NS)

// Default low-power wake interval in slow-oscillator ticks
`define PRC_WAKE_CYC 16'h0400

`endif

// ---- shared/prc_pkg.sv ----
package prc_pkg;
    typedef enum logic [6:0] {
        PRC_SHUTDOWN = 7'b000_0001,
        PRC_SETTLE   = 7'b000_0010,
        PRC_OTP_LOAD = 7'b000_0100,
        PRC_TRANSPORT = 7'b000_1000,
        PRC_ACTIVE   = 7'b001_0000,
        PRC_LOWPOWER = 7'b010_0000,
        PRC_WAKE     = 7'b100_0000
    } prc_state_t;
endpackage

// ---- src/prc_rf_gate.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "prc_defs.svh"

module prc_rf_gate (
    // Clock and control
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_run,
    // Packet framing
    input wire logic i_tx_active,
    input wire logic i_rx_active,
    input wire logic i_rf_needed,
    // RF enable
    output logic o_rf_on
);
    logic rf_on_r;
    logic rf_on_nxt;

    // RF on only in the live parts of a packet
    always_comb begin
        rf_on_nxt = i_run && (i_tx_active || i_rx_active) && i_rf_needed;
    end

    // Register the gate
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rf_on_r <= 1'b0;
        end else if (i_ce) begin
            rf_on_r <= rf_on_nxt;
        end
    end

    assign o_rf_on = rf_on_r;
endmodule

`default_nettype wire

// ---- src/prc_top.sv ----
// Behaviour
// - Shutdown tristates outputs, stops all clocks
// - Regulator enable acts as full power-up
// - Power-on reset sets every circuit defined
// - Low reset input forces power-on state
// - Low-power modes use slow oscillator, timed wake
// - RF gated on and off within packets
// - Boot memory disabled after boot completes
// - Boot memory holds 128 bytes
// - Disable pin high at settle end keeps boot memory off
// - Correction entries hidden from customer reads
`timescale 1ns/100ps
`default_nettype none
`include "prc_defs.svh"

module prc_top #(
    parameter int OTP_BYTES = `PRC_OTP_BYTES,
    parameter int SETTLE_CYC = `PRC_SETTLE_CYC,
    parameter logic [15:0] WAKE_CYC = `PRC_WAKE_CYC
) (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Power pins
    input wire logic i_reg_en,
    input wire logic i_onetime_memory_disable_pin,
    input wire logic i_io_supply_rail,
    // Low-power oscillator tick and mode request
    input wire logic i_low_power_oscillator_tick,
    input wire logic i_lowpower_req,
    input wire logic [15:0] i_wake_interval,
    // Transport stage done
    input wire logic i_transport_done,
    // Packet framing
    input wire logic i_tx_active,
    input wire logic i_rx_active,
    input wire logic i_rf_needed,
    // Customer boot-memory read port
    input wire logic i_otp_rd,
    input wire logic [`PRC_OTP_AW-1:0] i_otp_addr,
    // Boot-memory program port (manufacturing)
    input wire logic i_otp_wr,
    input wire logic [7:0] i_otp_wdata,
    // Status and controls
    output prc_pkg::prc_state_t o_state,
    output logic o_clk_en,
    output logic o_out_en_n,
    output logic o_core_rst_n,
    output logic o_otp_enabled,
    output logic o_otp_loaded,
    output logic o_on_slow_clock,
    output logic o_rf_on,
    output logic [7:0] o_otp_rdata,
    output logic o_otp_rvalid
);
    import prc_pkg::*;

    localparam int SC_W = $clog2(SETTLE_CYC + 1);

    // Refuse geometry or timing the logic cannot serve
    if (OTP_BYTES != 128 || SETTLE_CYC < 1) begin : g_bad_param
        $error("prc_top: unsupported parameter values");
    end

    // Hidden bytes are never shown to customers
    function automatic logic is_user_addr(input logic [`PRC_OTP_AW-1:0] a);
        is_user_addr = (a < `PRC_OTP_USER_LIMIT);
    endfunction

    logic [7:0] otp_mem [0:OTP_BYTES-1];
    prc_state_t state_r, state_nxt;
    logic [SC_W-1:0] settle_r, settle_nxt;
    logic [15:0] wake_r, wake_nxt;
    logic [`PRC_OTP_AW-1:0] ld_r, ld_nxt;
    logic otp_en_r, otp_en_nxt;
    logic loaded_r, loaded_nxt;
    logic clk_en_r, clk_en_nxt;
    logic oen_n_r, oen_n_nxt;
    logic core_rst_n_r, core_rst_n_nxt;
    logic slow_r, slow_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [7:0] shadow_r, shadow_nxt;
    logic pwr_off;

    // Power absent or regulator off means shutdown
    assign pwr_off = !i_reg_en || !i_io_supply_rail;

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        settle_nxt = settle_r;
        wake_nxt = wake_r;
        ld_nxt = ld_r;
        otp_en_nxt = otp_en_r;
        loaded_nxt = loaded_r;
        shadow_nxt = shadow_r;
        rdata_nxt = 8'h00;
        rvalid_nxt = 1'b0;
        case (state_r)
            PRC_SHUTDOWN: begin
                settle_nxt = '0;
                loaded_nxt = 1'b0;
                otp_en_nxt = 1'b0;
                if (!pwr_off) begin
                    state_nxt = PRC_SETTLE;
                end
            end
            PRC_SETTLE: begin
                settle_nxt = settle_r + 1'b1;
                if (settle_r == SC_W'(SETTLE_CYC - 1)) begin
                    state_nxt = PRC_OTP_LOAD;
                    ld_nxt = '0;
                    otp_en_nxt = !i_onetime_memory_disable_pin;
                end
            end
            PRC_OTP_LOAD: begin
                if (!otp_en_r) begin
                    state_nxt = PRC_TRANSPORT;
                end else begin
                    shadow_nxt = otp_mem[ld_r];
                    ld_nxt = ld_r + 1'b1;
                    if (ld_r == `PRC_OTP_AW'(OTP_BYTES - 1)) begin
                        loaded_nxt = 1'b1;
                        state_nxt = PRC_TRANSPORT;
                    end
                end
            end
            PRC_TRANSPORT: begin
                if (i_transport_done) begin
                    state_nxt = PRC_ACTIVE;
                    otp_en_nxt = 1'b0;
                end
            end
            PRC_ACTIVE: begin
                if (i_lowpower_req) begin
                    state_nxt = PRC_LOWPOWER;
                    wake_nxt = (i_wake_interval == 16'h0000) ? WAKE_CYC : i_wake_interval;
                end
            end
            PRC_LOWPOWER: begin
                if (i_low_power_oscillator_tick) begin
                    wake_nxt = wake_r - 16'h0001;
                    if (wake_r == 16'h0001) begin
                        state_nxt = PRC_WAKE;
                    end
                end
            end
            PRC_WAKE: begin
                state_nxt = PRC_ACTIVE;
            end
            default: begin
                state_nxt = PRC_SHUTDOWN;
            end
        endcase
        // Customer reads only while boot memory is enabled
        if (otp_en_r && i_otp_rd) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = is_user_addr(i_otp_addr) ? otp_mem[i_otp_addr] : 8'h00;
        end
        if (pwr_off) begin
            state_nxt = PRC_SHUTDOWN;
        end
    end

    // Output controls derived from next state
    always_comb begin
        clk_en_nxt = (state_nxt != PRC_SHUTDOWN) && (state_nxt != PRC_LOWPOWER);
        oen_n_nxt = (state_nxt == PRC_SHUTDOWN);
        core_rst_n_nxt = (state_nxt != PRC_SHUTDOWN) && (state_nxt != PRC_SETTLE);
        slow_nxt = (state_nxt == PRC_LOWPOWER);
    end

    // Register all state; reset forces power-on state
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_r <= PRC_SHUTDOWN;
            settle_r <= '0;
            wake_r <= 16'h0000;
            ld_r <= '0;
            otp_en_r <= 1'b0;
            loaded_r <= 1'b0;
            shadow_r <= 8'h00;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            clk_en_r <= 1'b0;
            oen_n_r <= 1'b1;
            core_rst_n_r <= 1'b0;
            slow_r <= 1'b0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            settle_r <= settle_nxt;
            wake_r <= wake_nxt;
            ld_r <= ld_nxt;
            otp_en_r <= otp_en_nxt;
            loaded_r <= loaded_nxt;
            shadow_r <= shadow_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            clk_en_r <= clk_en_nxt;
            oen_n_r <= oen_n_nxt;
            core_rst_n_r <= core_rst_n_nxt;
            slow_r <= slow_nxt;
        end
    end

    // Manufacturing programming, write-once per byte
    always_ff @(posedge i_clk_sys) begin
        if (i_ce && otp_en_r && i_otp_wr && otp_mem[i_otp_addr] == 8'h00) begin
            otp_mem[i_otp_addr] <= i_otp_wdata;
        end
    end

    // RF gating within packets
    prc_rf_gate u_rf_gate (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_run(state_r == PRC_ACTIVE),
        .i_tx_active(i_tx_active),
        .i_rx_active(i_rx_active),
        .i_rf_needed(i_rf_needed),
        .o_rf_on(o_rf_on)
    );

    assign o_state = state_r;
    assign o_clk_en = clk_en_r;
    assign o_out_en_n = oen_n_r;
    assign o_core_rst_n = core_rst_n_r;
    assign o_otp_enabled = otp_en_r;
    assign o_otp_loaded = loaded_r;
    assign o_on_slow_clock = slow_r;
    assign o_otp_rdata = rdata_r;
    assign o_otp_rvalid = rvalid_r;
endmodule

`default_nettype wire

// ---- tb/prc_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module prc_host_model (
    // Bench commands
    input wire logic i_clk_sys,
    input wire logic i_pwr_cmd,
    input wire logic i_rst_cmd,
    input wire logic i_strap_cmd,
    // Host pins
    output logic o_reg_en = 1'b0,
    output logic o_rst_n = 1'b0,
    output logic o_dis_pin = 1'b0
);
    // Pins move on the clock like a host GPIO port
    always @(posedge i_clk_sys) begin
        o_reg_en <= i_pwr_cmd;
        o_rst_n <= !i_rst_cmd;
        o_dis_pin <= i_strap_cmd;
    end
endmodule

`default_nettype wire

// ---- tb/prc_top_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none

module prc_top_monitor (
    // Clock, reset, pins
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_reg_en,
    input wire logic i_onetime_memory_disable_pin,
    // Framing and reads
    input wire logic i_tx_active,
    input wire logic i_rx_active,
    input wire logic i_rf_needed,
    input wire logic i_otp_rd,
    input wire logic [6:0] i_otp_addr,
    // Outputs watched
    input wire prc_pkg::prc_state_t o_state,
    input wire logic o_clk_en,
    input wire logic o_out_en_n,
    input wire logic o_core_rst_n,
    input wire logic o_otp_enabled,
    input wire logic o_on_slow_clock,
    input wire logic o_rf_on,
    input wire logic [7:0] o_otp_rdata,
    input wire logic o_otp_rvalid
);
    import prc_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Leaving settle into the boot-memory load
    sequence boot_load_s;
        o_state == PRC_SETTLE ##1 o_state == PRC_OTP_LOAD;
    endsequence
    shut_outputs_off_a: assert property (o_state == PRC_SHUTDOWN |-> o_out_en_n && !o_clk_en)
        else $error("shutdown left outputs or clocks on");
    regoff_shutdown_a: assert property (!i_reg_en |=> o_state == PRC_SHUTDOWN)
        else $error("regulator off without shutdown");
    rst_forces_por_a: assert property (disable iff (1'b0)
        !i_rst_n |=> o_state == PRC_SHUTDOWN && !o_core_rst_n) else $error("reset not obeyed");
    lowpower_slow_a: assert property (o_state == PRC_LOWPOWER |-> o_on_slow_clock && !o_clk_en)
        else $error("low power not on slow clock");
    rf_follow_a: assert property (1 |=> o_rf_on ==
        $past(o_state == PRC_ACTIVE && (i_tx_active || i_rx_active) && i_rf_needed))
        else $error("rf enable wrong");
    otp_off_active_a: assert property (o_state == PRC_ACTIVE |-> !o_otp_enabled)
        else $error("boot memory on after boot");
    strap_sampled_a: assert property (boot_load_s |->
        o_otp_enabled == !$past(i_onetime_memory_disable_pin)) else $error("strap ignored");
    hidden_read_zero_a: assert property (i_otp_rd && o_otp_enabled && i_otp_addr >= 7'h70
        |=> o_otp_rvalid && o_otp_rdata == 8'h00) else $error("hidden byte visible");
endmodule

bind prc_top prc_top_monitor u_mon (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_reg_en(i_reg_en), .i_onetime_memory_disable_pin(i_onetime_memory_disable_pin),
    .i_tx_active(i_tx_active), .i_rx_active(i_rx_active), .i_rf_needed(i_rf_needed),
    .i_otp_rd(i_otp_rd), .i_otp_addr(i_otp_addr), .o_state(o_state), .o_clk_en(o_clk_en),
    .o_out_en_n(o_out_en_n), .o_core_rst_n(o_core_rst_n), .o_otp_enabled(o_otp_enabled),
    .o_on_slow_clock(o_on_slow_clock), .o_rf_on(o_rf_on), .o_otp_rdata(o_otp_rdata),
    .o_otp_rvalid(o_otp_rvalid));

`default_nettype wire

// ---- tb/test_power_reset_otp_control.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_power_reset_otp_control;
    import prc_pkg::*;
    logic clk = 0, pwr = 0, rstc = 1, strap = 0, tick = 0, lpr = 0, tdone = 0;
    logic tx = 0, rx = 0, rfn = 0, rd = 0, reg_en, rst_n, dpin, core_rst_n, oen_n, otp_en;
    logic slow, rf_on, rvalid, clk_en, loaded, ce = 1, rail = 1;
    logic [15:0] wiv = 16'h0003;
    int tick_seen = 0;
    logic [6:0] addr = 7'h00;
    logic [7:0] rdata;
    logic [7:0] exp_q[$];
    prc_state_t st;
    int failures = 0, cmp_count = 0;

    prc_host_model hm (.i_clk_sys(clk), .i_pwr_cmd(pwr), .i_rst_cmd(rstc), .i_strap_cmd(strap),
        .o_reg_en(reg_en), .o_rst_n(rst_n), .o_dis_pin(dpin));
    prc_top #(.SETTLE_CYC(4)) uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_reg_en(reg_en), .i_onetime_memory_disable_pin(dpin), .i_io_supply_rail(rail),
        .i_low_power_oscillator_tick(tick), .i_lowpower_req(lpr), .i_wake_interval(wiv),
        .i_transport_done(tdone), .i_tx_active(tx), .i_rx_active(rx), .i_rf_needed(rfn),
        .i_otp_rd(rd), .i_otp_addr(addr), .i_otp_wr(1'b0), .i_otp_wdata(8'h00), .o_state(st),
        .o_clk_en(clk_en), .o_out_en_n(oen_n), .o_core_rst_n(core_rst_n),
        .o_otp_enabled(otp_en), .o_otp_loaded(loaded), .o_on_slow_clock(slow),
        .o_rf_on(rf_on), .o_otp_rdata(rdata),
        .o_otp_rvalid(rvalid));

    // Clock and random slow-oscillator ticks
    initial forever #12.5 clk = ~clk;
    always begin
        @(posedge clk);
        #1;
        tick = ($urandom % 3 == 0);
    end

    // Count slow ticks the sequencer consumes while asleep
    always @(posedge clk) begin
        if (st === PRC_LOWPOWER && tick === 1'b1) tick_seen++;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_st(input prc_state_t s);
        for (int n = 0; n < 500 && st !== s; n++) step(1);
        chk("state", s, st);
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Power-up, timed load, hidden reads, then transport done
    task automatic boot(input logic pin);
        int n;
        strap = pin;
        tdone = 0;
        pwr = 1;
        wait_st(PRC_OTP_LOAD);
        for (n = 0; n < 300 && st === PRC_OTP_LOAD; n++) step(1);
        chk("load_len", pin ? 8'h01 : 8'h80, 8'(n));
        chk("otp_en", !pin, otp_en);
        chk("loaded", !pin, loaded);
        for (int i = 0; i < 4; i++) begin
            rd = 1;
            addr = 7'h70 + 7'($urandom % 16);
            if (!pin) exp_q.push_back(8'h00);
            step(1);
        end
        rd = 0;
        step(2);
        chk("pending", 8'h00, 8'(exp_q.size()));
        tdone = 1;
        wait_st(PRC_ACTIVE);
        chk("otp_off", 0, otp_en);
    endtask

    // Read answers against noted expectations
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0)
                chk("rvalid", 0, 1);
            else
                chk("rdata", exp_q.pop_front(), rdata);
        end
    end

    initial begin
        void'($urandom(32'h9fb7));
        wiv = 16'(1 + $urandom % 6);
        step(5);
        rstc = 0;
        boot(0);
        tx = 1;
        rfn = 1;
        step(2);
        chk("rf_on", 1, rf_on);
        tx = 0;
        rx = 1;
        rfn = 0;
        step(2);
        chk("rf_off", 0, rf_on);
        ce = 0;
        lpr = 1;
        step(3);
        chk("frozen", PRC_ACTIVE, st);
        ce = 1;
        wait_st(PRC_LOWPOWER);
        chk("slow", 1, slow);
        chk("clk_en", 0, clk_en);
        lpr = 0;
        wait_st(PRC_ACTIVE);
        chk("ticks", wiv[7:0], 8'(tick_seen));
        pwr = 0;
        step(3);
        chk("oen_n", 1, oen_n);
        chk("off", PRC_SHUTDOWN, st);
        boot(1);
        rail = 0;
        step(2);
        chk("rail_off", PRC_SHUTDOWN, st);
        rail = 1;
        wait_st(PRC_ACTIVE);
        chk("core_up", 1, core_rst_n);
        rstc = 1;
        step(3);
        chk("core_rst_n", 0, core_rst_n);
        chk("rst_st", PRC_SHUTDOWN, st);
        give_verdict;
    end

    // Watchdog
    initial begin
        #200000;
        failures++;
        give_verdict;
    end
endmodule

`default_nettype wire
